// File: verilog/pin_pwr_irq_pkg.sv
// constants shared by the pin and power group interrupt block
// assumes a 16-bit register port with word indices 0 and 1
package pin_pwr_irq_pkg;
  // register indices on the plain port
  localparam logic [3:0] PIN_CTRL_ADDR = 4'h0;
  localparam logic [3:0] PWR_CTRL_ADDR = 4'h1;
  // pin control field positions
  localparam int PIN_FLAG_POS = 15;
  localparam int PIN_LEVEL_POS = 6;
  localparam int PIN_DIR_POS = 4;
  localparam int PIN_OUT_POS = 3;
  localparam int PIN_EDGE_POS = 2;
  localparam int PIN_PRIO_POS = 1;
  localparam int PIN_EN_POS = 0;
  // power group field positions
  localparam int PWR_FLAG_POS = 15;
  localparam int PWR_LEVEL_LSB = 8;
  localparam int PWR_MASTER_POS = 7;
  localparam int PWR_EN_LSB = 0;
  localparam int PWR_SRC_N = 7;
  // values after reset
  localparam logic [4:0] PIN_CFG_RESET = 5'h00;
  localparam logic [6:0] PWR_EN_RESET = 7'h00;
  // reserved bits read as this constant
  localparam logic [15:0] RESERVED_READ = 16'h0000;
  // per-source active level: 1 active high, 0 active low; fixed in silicon
  localparam logic [6:0] PWR_SRC_ACTIVE_HIGH = 7'h7f;
endpackage : pin_pwr_irq_pkg

// File: verilog/pin_pwr_irq.sv
// pin interrupt and seven-source power group interrupt logic
// assumes a plain register port on clk_i, pins and fault lines asynchronous
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - selected pin edge always sets pin flag
// - pin flag cleared by software, request pulse unaffected
// - one request pulse per selected edge
// - bit 6 reads live pin level
// - reserved pin bits ignore writes
// - direction bit picks input or output
// - output value bit drives pin level
// - edge select: falling 0, rising 1
// - priority bit picks high or low
// - enable gates requests, else plain io
// - no nonmaskable path exists
// - seven sources share one request
// - group priority fixed in hardware
// - source polarity fixed per source
// - enabled source edge sets group flag
// - group flag cleared only by zero write
// - level bits show active source state
// - master enable gates group request
// - master enable gates wakeup too
// - per-source enables gate flag setting
module pin_pwr_irq
  import pin_pwr_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic pin_irq_hi_o,
  output logic pin_irq_lo_o,
  input wire logic [6:0] pwr_src_i,
  output logic pwr_irq_o,
  output logic pwr_wakeup_o
);

  // two-stage synchronisers
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic pin_prev_reg;
  logic [6:0] src_s1_reg;
  logic [6:0] src_s2_reg;
  logic [6:0] src_prev_reg;
  // control state
  logic pin_flag_reg;
  logic pin_flag_next;
  logic [4:0] pin_cfg_reg;
  logic [4:0] pin_cfg_next;
  logic pin_pend_reg;
  logic pin_pend_next;
  logic pwr_flag_reg;
  logic pwr_flag_next;
  logic pwr_master_reg;
  logic pwr_master_next;
  logic [6:0] pwr_en_reg;
  logic [6:0] pwr_en_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= pin_i;
      pin_s2_reg <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  // source sync; reset to the inactive level so no false edge follows
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      src_s1_reg <= ~PWR_SRC_ACTIVE_HIGH;
      src_s2_reg <= ~PWR_SRC_ACTIVE_HIGH;
      src_prev_reg <= ~PWR_SRC_ACTIVE_HIGH;
    end
    else
    begin
      src_s1_reg <= pwr_src_i;
      src_s2_reg <= src_s1_reg;
      src_prev_reg <= src_s2_reg;
    end
  end

  // decoded fields of the pin configuration
  wire cfg_en = pin_cfg_reg[0];
  wire cfg_prio = pin_cfg_reg[1];
  wire cfg_edge = pin_cfg_reg[2];
  wire cfg_out = pin_cfg_reg[3];
  wire cfg_dir = pin_cfg_reg[4];
  wire wr_pin = wr_i && (addr_i == PIN_CTRL_ADDR);
  wire wr_pwr = wr_i && (addr_i == PWR_CTRL_ADDR);

  wire rise_seen = pin_s2_reg && !pin_prev_reg;
  wire fall_seen = !pin_s2_reg && pin_prev_reg;
  wire pin_edge = cfg_edge ? rise_seen : fall_seen;

  // clear-write: writing 1 to bit 15 clears the flag
  wire pin_clr = wr_pin && wdata_i[PIN_FLAG_POS];

  // flag set regardless of enable, set wins over clear
  assign pin_flag_next = pin_edge ? 1'b1 : (pin_clr ? 1'b0 : pin_flag_reg);

  assign pin_cfg_next = wr_pin ?
    {wdata_i[PIN_DIR_POS], wdata_i[PIN_OUT_POS], wdata_i[PIN_EDGE_POS],
     wdata_i[PIN_PRIO_POS], wdata_i[PIN_EN_POS]} : pin_cfg_reg;

  // each enabled edge yields one request pulse; a clear does not withdraw it
  assign pin_pend_next = cfg_en && pin_edge && !(pin_clr && !pin_edge);

  wire [6:0] src_active = ~(src_s2_reg ^ PWR_SRC_ACTIVE_HIGH);
  wire [6:0] src_active_prev = ~(src_prev_reg ^ PWR_SRC_ACTIVE_HIGH);
  wire [6:0] src_edge = src_active & ~src_active_prev;

  wire pwr_set = |(src_edge & pwr_en_reg);
  // writing 0 clears, 1 leaves flag
  wire pwr_clr = wr_pwr && !wdata_i[PWR_FLAG_POS];
  // enabled edge sets flag, set wins over clear
  assign pwr_flag_next = pwr_set ? 1'b1 : (pwr_clr ? 1'b0 : pwr_flag_reg);
  assign pwr_master_next = wr_pwr ? wdata_i[PWR_MASTER_POS] : pwr_master_reg;
  assign pwr_en_next = wr_pwr ? wdata_i[PWR_EN_LSB +: PWR_SRC_N] : pwr_en_reg;

  // read mux; live level; source levels
  wire [15:0] pin_rd = RESERVED_READ |
    {pin_flag_reg, 8'h00, pin_s2_reg, 1'b0, cfg_dir, cfg_out, cfg_edge, cfg_prio, cfg_en};
  wire [15:0] pwr_rd = {pwr_flag_reg, src_active, pwr_master_reg, pwr_en_reg};
  assign rdata_next = !rd_i ? 16'h0000 :
    (addr_i == PIN_CTRL_ADDR) ? pin_rd :
    (addr_i == PWR_CTRL_ADDR) ? pwr_rd : 16'h0000;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_flag_reg <= 1'b0;
      pin_cfg_reg <= PIN_CFG_RESET;
      pin_pend_reg <= 1'b0;
    end
    else
    begin
      pin_flag_reg <= pin_flag_next;
      pin_cfg_reg <= pin_cfg_next;
      pin_pend_reg <= pin_pend_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pwr_flag_reg <= 1'b0;
      pwr_master_reg <= 1'b0;
      pwr_en_reg <= PWR_EN_RESET;
    end
    else
    begin
      pwr_flag_reg <= pwr_flag_next;
      pwr_master_reg <= pwr_master_next;
      pwr_en_reg <= pwr_en_next;
    end
  end

  // read data register, zero outside the answer cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= 16'h0000;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;

  // direction applies only while interrupt disabled
  // enabled pin is always an input
  assign pin_oe_o = !cfg_en && cfg_dir;
  assign pin_o = cfg_out;

  assign pin_irq_hi_o = pin_pend_reg && !cfg_prio;
  assign pin_irq_lo_o = pin_pend_reg && cfg_prio;

  // one shared request; no priority control
  assign pwr_irq_o = pwr_master_reg && pwr_flag_reg;
  assign pwr_wakeup_o = pwr_master_reg && |(src_active & pwr_en_reg);

  pin_flag_set_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i) pin_edge |=> pin_flag_reg)
    else $error("pin flag not set after edge");
  pin_flag_hold_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pin_flag_reg && !pin_clr) |=> pin_flag_reg)
    else $error("pin flag dropped without clear");
  pin_req_each_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pin_edge && cfg_en) |=> (pin_irq_hi_o || pin_irq_lo_o))
    else $error("edge gave no request");
  pin_req_block_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !$past(cfg_en) |-> !(pin_irq_hi_o || pin_irq_lo_o))
    else $error("request while pin disabled");
  pin_dir_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pin_oe_o |-> (cfg_dir && !cfg_en))
    else $error("pin driven wrongly");
  pin_prio_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pin_irq_lo_o |-> (cfg_prio && !pin_irq_hi_o))
    else $error("priority routing wrong");
  pwr_flag_set_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i) pwr_set |=> pwr_flag_reg)
    else $error("group flag not set");
  pwr_flag_keep_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pwr_flag_reg && wr_pwr && wdata_i[PWR_FLAG_POS]) |=> pwr_flag_reg)
    else $error("group flag cleared by 1");
  pwr_master_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !pwr_master_reg |-> !(pwr_irq_o || pwr_wakeup_o))
    else $error("group request while master off");
  pwr_src_gate_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!pwr_flag_reg && !(|(src_edge & pwr_en_reg))) |=> !pwr_flag_reg)
    else $error("flag set by disabled source");
  pin_flag_clear_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pin_clr && !pin_edge) |=> !pin_flag_reg)
    else $error("pin flag survived clear");
  pin_cfg_stable_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_pin |=> $stable(pin_cfg_reg))
    else $error("pin config changed without write");
  pin_req_cause_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pin_irq_hi_o || pin_irq_lo_o) |-> $past(pin_edge))
    else $error("request without edge");
  pin_level_read_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && (addr_i == PIN_CTRL_ADDR)) |=> (rdata_o[PIN_LEVEL_POS] == $past(pin_s2_reg)))
    else $error("pin level bit wrong");
  pin_drive_high_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_pin && !wdata_i[PIN_EN_POS] && wdata_i[PIN_DIR_POS] && wdata_i[PIN_OUT_POS])
    |=> (pin_oe_o && pin_o))
    else $error("pin not driven high");
  pin_drive_low_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_pin && !wdata_i[PIN_EN_POS] && wdata_i[PIN_DIR_POS] && !wdata_i[PIN_OUT_POS])
    |=> (pin_oe_o && !pin_o))
    else $error("pin not driven low");
  pin_en_input_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_pin && wdata_i[PIN_EN_POS]) |=> !pin_oe_o)
    else $error("enabled pin driven");
  // flag sets only on selected edge
  pin_flag_cause_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!pin_flag_reg && !pin_edge) |=> !pin_flag_reg)
    else $error("pin flag set without edge");
  pin_hi_route_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pin_edge && cfg_en && !cfg_prio && !wr_pin) |=> pin_irq_hi_o)
    else $error("high request missing");
  pin_lo_route_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pin_edge && cfg_en && cfg_prio && !wr_pin) |=> pin_irq_lo_o)
    else $error("low request missing");
  pin_reset_a:
  assert property (@(posedge clk_i)
    !rst_n_i |=> ((pin_cfg_reg == PIN_CFG_RESET) && !pin_flag_reg
      && !pin_oe_o && !pin_pend_reg))
    else $error("pin state not reset");
  pwr_reset_a:
  assert property (@(posedge clk_i)
    !rst_n_i |=> (!pwr_flag_reg && !pwr_master_reg && (pwr_en_reg == PWR_EN_RESET)))
    else $error("group state not reset");
  pwr_flag_clear_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pwr_clr && !pwr_set) |=> !pwr_flag_reg)
    else $error("group flag survived clear");
  pwr_level_read_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && (addr_i == PWR_CTRL_ADDR)) |=>
    (rdata_o[PWR_LEVEL_LSB +: PWR_SRC_N] == ~($past(src_s2_reg) ^ PWR_SRC_ACTIVE_HIGH)))
    else $error("source level bits wrong");
  pwr_wake_gate_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_pwr && !wdata_i[PWR_MASTER_POS]) |=> !pwr_wakeup_o)
    else $error("wakeup while master off");
  // any enabled source raises shared request
  pwr_irq_shared_a:
  assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pwr_set && pwr_master_reg && !wr_pwr) |=> pwr_irq_o)
    else $error("shared request missing");

endmodule // pin_pwr_irq
`default_nettype wire

// File: tb/pin_pwr_partner.sv
// model of the external pin and the fault lines
// assumes the bench sets the levels at clock edges
`timescale 1ns/10ps
`default_nettype none
module pin_pwr_partner
(
  input wire logic ext_i,
  input wire logic [6:0] src_i,
  input wire logic drv_i,
  input wire logic drv_oe_i,
  output logic pin_o,
  output logic [6:0] src_o
);
  assign pin_o = drv_oe_i ? drv_i : ext_i;
  assign src_o = src_i;
endmodule // pin_pwr_partner
`default_nettype wire

// File: tb/pin_pwr_irq_tb.sv
// self-checking bench for the pin and power group interrupt block
// assumes the partner model resolves the pin wire
`timescale 1ns/10ps
`default_nettype none
module pin_pwr_irq_tb;
  import pin_pwr_irq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ext = 1'b0;
  logic [6:0] src = 7'h00;
  logic [15:0] rdata_o, v;
  logic pin_w, pin_o, pin_oe_o, pin_irq_hi_o, pin_irq_lo_o, pwr_irq_o, pwr_wakeup_o;
  logic [6:0] pwr_src;
  int bad_count = 0;
  int cmp_count = 0;
  int hi_n = 0;
  int lo_n = 0;
  always #10 clk_i = ~clk_i;
  // count request pulses
  always @(posedge clk_i)
  begin
    hi_n <= hi_n + int'(pin_irq_hi_o === 1'b1);
    lo_n <= lo_n + int'(pin_irq_lo_o === 1'b1);
  end
  pin_pwr_partner i_far (.ext_i(ext), .src_i(src), .drv_i(pin_o), .drv_oe_i(pin_oe_o),
    .pin_o(pin_w), .src_o(pwr_src));
  pin_pwr_irq i_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .pin_i(pin_w), .pin_o, .pin_oe_o, .pin_irq_hi_o, .pin_irq_lo_o,
    .pwr_src_i(pwr_src), .pwr_irq_o, .pwr_wakeup_o);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data land in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // set the pin and let the synchroniser settle
  task automatic pin(input logic l);
    @(posedge clk_i);
    ext <= l;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic t_reset;
    rd(PIN_CTRL_ADDR);
    chk(v, 16'h0000, "pin reset");
    rd(PWR_CTRL_ADDR);
    chk(v, 16'h0000, "pwr reset");
    rd(4'h5);
    chk(v, 16'h0000, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_pin;
    wr(PIN_CTRL_ADDR, 16'h7fe4);
    rd(PIN_CTRL_ADDR);
    chk(v, 16'h0004, "reserved bits");
    pin(1'b1);
    rd(PIN_CTRL_ADDR);
    chk(v, 16'h8044, "flag while masked");
    chk(16'(hi_n + lo_n), 16'h0000, "masked request");
    wr(PIN_CTRL_ADDR, 16'h0005);
    pin(1'b0);
    pin(1'b1);
    pin(1'b0);
    pin(1'b1);
    chk(16'(hi_n), 16'h0002, "pulse per edge");
    wr(PIN_CTRL_ADDR, 16'h8003);
    rd(PIN_CTRL_ADDR);
    chk(v, 16'h0043, "flag cleared");
    pin(1'b0);
    chk(16'(lo_n), 16'h0001, "falling low prio");
    $display("test pin done");
  endtask
  task automatic t_gpio;
    wr(PIN_CTRL_ADDR, 16'h8018);
    repeat (4) @(posedge clk_i);
    rd(PIN_CTRL_ADDR);
    chk(v, 16'h0058, "drive high");
    chk(16'(pin_oe_o), 16'h0001, "output dir");
    chk(16'(pin_o), 16'h0001, "pin high");
    wr(PIN_CTRL_ADDR, 16'h0010);
    repeat (4) @(posedge clk_i);
    rd(PIN_CTRL_ADDR);
    chk(v, 16'h8010, "drive low");
    chk(16'(pin_o), 16'h0000, "pin low");
    wr(PIN_CTRL_ADDR, 16'h0019);
    repeat (2) @(posedge clk_i);
    chk(16'(pin_oe_o), 16'h0000, "enable frees pin");
    $display("test gpio done");
  endtask
  task automatic t_pwr;
    wr(PWR_CTRL_ADDR, 16'h0088);
    @(posedge clk_i);
    src <= 7'h09;
    repeat (4) @(posedge clk_i);
    rd(PWR_CTRL_ADDR);
    chk(v, 16'h8988, "flag and levels");
    chk({14'h0, pwr_irq_o, pwr_wakeup_o}, 16'h0003, "irq wake");
    wr(PWR_CTRL_ADDR, 16'h8088);
    rd(PWR_CTRL_ADDR);
    chk(v, 16'h8988, "one keeps flag");
    wr(PWR_CTRL_ADDR, 16'h0008);
    repeat (2) @(posedge clk_i);
    chk({14'h0, pwr_irq_o, pwr_wakeup_o}, 16'h0000, "master off");
    src <= 7'h00;
    repeat (4) @(posedge clk_i);
    src <= 7'h01;
    repeat (4) @(posedge clk_i);
    rd(PWR_CTRL_ADDR);
    chk(v, 16'h0108, "disabled source");
    $display("test power done");
  endtask
  // second reset in mid-run on dirty state
  task automatic t_rerun;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(PIN_CTRL_ADDR);
    chk(v, 16'h0000, "pin after rerun");
    rd(PWR_CTRL_ADDR);
    chk(v, 16'h0100, "pwr after rerun");
    chk({13'h0, pin_oe_o, pwr_irq_o, pwr_wakeup_o}, 16'h0000, "outs after rerun");
    $display("test rerun done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence after six reset cycles
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_pin;
    t_gpio;
    t_pwr;
    t_rerun;
    tally_and_finish;
  end
  // hang guard
  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish;
  end
endmodule // pin_pwr_irq_tb
`default_nettype wire
